// >>> verilog/ssp_strap_sampler.sv
// strap sampler top: strap capture, boot decode and wishbone registers
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "ssp_map.svh"

module ssp_strap_sampler #(
    parameter int NUM_STRAPS = `SSP_NUM_STRAPS,
    parameter int SETTLE_CYC = `SSP_SETTLE_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_enable,
    // strapping pins, five signals each
    input wire logic [NUM_STRAPS-1:0] strap_pin_i,
    output logic [NUM_STRAPS-1:0] strap_pin_o,
    output logic [NUM_STRAPS-1:0] strap_pin_oe,
    output logic [NUM_STRAPS-1:0] strap_pull_up_en,
    output logic [NUM_STRAPS-1:0] strap_pull_dn_en,
    // functional drive of the same pins once released
    input wire logic [NUM_STRAPS-1:0] func_o,
    input wire logic [NUM_STRAPS-1:0] func_oe,
    // chip state and decoded boot configuration
    output logic chip_run,
    output logic boot_from_flash,
    output logic download_boot,
    output logic boot_mode_undefined,
    output logic boot_log_enable,
    output logic flash_vdd_1v8,
    output logic sdio_in_rising,
    output logic sdio_out_rising,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    localparam logic [NUM_STRAPS-1:0] PULL_UP_MASK =
        NUM_STRAPS'(`SSP_PULL_UP_MASK);
    // a settle count of 1 still needs a one-bit counter
    localparam int CNT_W = (SETTLE_CYC < 2) ? 1 : $clog2(SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

    // ======================================================================
    // state
    // one record for every flop of the top level
    typedef struct packed {
        ssp_pkg::ssp_state_e state;
        logic [CNT_W-1:0] settle;
        logic captured;
        logic [`SSP_OV_WIDTH-1:0] ovr;
        logic ack;
        logic [31:0] rdata;
        logic run;
        logic flash_boot;
        logic download;
        logic undefined;
        logic log_en;
        logic vdd_1v8;
        logic in_rise;
        logic out_rise;
    } ssp_top_s;

    ssp_top_s top_q;
    ssp_top_s top_d;

    logic [NUM_STRAPS-1:0] strap_bits;
    logic pad_hold;
    logic pad_sample;

    // ======================================================================
    // strap pads
    // pads stay under their pulls until the latch has closed
    assign pad_hold = (top_q.state != ssp_pkg::SSP_ST_RUN);
    assign pad_sample = (top_q.state == ssp_pkg::SSP_ST_SETTLE) &&
                        (top_q.settle == SETTLE_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_STRAPS; gi = gi + 1) begin : g_pad
            ssp_strap_pad #(
                .PULL_UP(PULL_UP_MASK[gi])
            ) u_pad (
                .clock(clock),
                .reset(reset),
                .hold(pad_hold),
                .sample(pad_sample),
                .pin_i(strap_pin_i[gi]),
                .func_o(func_o[gi]),
                .func_oe(func_oe[gi]),
                .pin_o(strap_pin_o[gi]),
                .pin_oe(strap_pin_oe[gi]),
                .pull_up_en(strap_pull_up_en[gi]),
                .pull_dn_en(strap_pull_dn_en[gi]),
                .strap_q(strap_bits[gi])
            );
        end
    endgenerate

    // ======================================================================
    // next state
    logic bus_req;
    logic wr_ovr;
    logic [`SSP_OV_WIDTH-1:0] eff_ovr;
    logic [31:0] rd_word;
    logic [NUM_STRAPS-1:0] fresh;

    always_comb begin
        top_d = top_q;
        // ==================================================================
        // bus strobes
        // a request is taken once, then ack blocks it for the next cycle
        bus_req = wb_cyc_i && wb_stb_i && !top_q.ack;
        // write lands on the edge where the master sees ack, so a cycle
        // dropped before its ack leaves the override untouched
        wr_ovr = wb_cyc_i && wb_stb_i && top_q.ack && wb_we_i &&
                 wb_sel_i[0] && (wb_adr_i == `SSP_OFS_OVERRIDE);
        // pins as they stand now; only used on the latch edge
        fresh = strap_pin_i;
        eff_ovr = top_q.ovr;
        rd_word = 32'h0;

        // ==================================================================
        // sequencer
        case (top_q.state)
            ssp_pkg::SSP_ST_OFF: begin
                // clearing the latch flag forces a fresh sample on each enable
                top_d.run = 1'b0;
                top_d.settle = '0;
                top_d.captured = 1'b0;
                if (chip_enable) begin
                    top_d.state = ssp_pkg::SSP_ST_SETTLE;
                end
            end
            ssp_pkg::SSP_ST_SETTLE: begin
                top_d.run = 1'b0;
                if (!chip_enable) begin
                    top_d.state = ssp_pkg::SSP_ST_OFF;
                end else if (pad_sample) begin
                    // pads latch the pins on this same edge
                    top_d.state = ssp_pkg::SSP_ST_RUN;
                    top_d.captured = 1'b1;
                    top_d.run = 1'b1;
                    // reload overrides from the fresh strap levels
                    top_d.ovr[`SSP_OV_VDD_1V8] =
                        fresh[`SSP_BIT_SUPPLY];
                    top_d.ovr[`SSP_OV_SDIO_IN_RISE] =
                        fresh[`SSP_BIT_LOG_EDGE];
                    top_d.ovr[`SSP_OV_SDIO_OUT_RISE] =
                        fresh[`SSP_BIT_SDIO_EDGE];
                end else begin
                    // window lets board resistors overcome the weak pulls
                    top_d.settle = top_q.settle + CNT_W'(1);
                end
            end
            ssp_pkg::SSP_ST_RUN: begin
                // latch holds until shutdown, whatever the pins do
                if (!chip_enable) begin
                    top_d.state = ssp_pkg::SSP_ST_OFF;
                    top_d.run = 1'b0;
                end else begin
                    top_d.run = 1'b1;
                    // overrides reach the outputs on the write edge itself
                    if (wr_ovr) begin
                        top_d.ovr = wb_dat_i[`SSP_OV_WIDTH-1:0];
                    end
                end
            end
            default: begin
                // unused code: go safe, chip held off
                top_d.state = ssp_pkg::SSP_ST_OFF;
                top_d.run = 1'b0;
            end
        endcase

        // ==================================================================
        // boot decode from the pins on the latch edge, supply and sdio edges from the overrides
        eff_ovr = top_d.ovr;
        if (top_d.captured) begin
            if (top_q.state == ssp_pkg::SSP_ST_SETTLE) begin
                // taken from the pins on the latch edge, rises with chip_run
                top_d.flash_boot = fresh[`SSP_BIT_BOOT];
                top_d.download = !fresh[`SSP_BIT_BOOT] &&
                                 !fresh[`SSP_BIT_QUALIFY];
                // boot 0 with qualify 1 has no defined mode: flagged only
                top_d.undefined = !fresh[`SSP_BIT_BOOT] &&
                                  fresh[`SSP_BIT_QUALIFY];
                top_d.log_en = fresh[`SSP_BIT_LOG_EDGE];
            end
            top_d.vdd_1v8 = eff_ovr[`SSP_OV_VDD_1V8];
            top_d.in_rise = eff_ovr[`SSP_OV_SDIO_IN_RISE];
            top_d.out_rise = eff_ovr[`SSP_OV_SDIO_OUT_RISE];
        end else begin
            // chip held off: nothing decoded
            top_d.flash_boot = 1'b0;
            top_d.download = 1'b0;
            top_d.undefined = 1'b0;
            top_d.log_en = 1'b0;
            top_d.vdd_1v8 = 1'b0;
            top_d.in_rise = 1'b0;
            top_d.out_rise = 1'b0;
        end

        // ==================================================================
        // register read mux
        case (wb_adr_i)
            `SSP_OFS_STATUS: begin
                rd_word[`SSP_ST_STRAPS_LSB +: NUM_STRAPS] = strap_bits;
                rd_word[`SSP_ST_CAPTURED] = top_q.captured;
                rd_word[`SSP_ST_RUNNING] = top_q.run;
            end
            `SSP_OFS_OVERRIDE: begin
                rd_word[`SSP_OV_WIDTH-1:0] = top_q.ovr;
            end
            `SSP_OFS_MODE: begin
                rd_word[`SSP_MD_FLASH_BOOT] = top_q.flash_boot;
                rd_word[`SSP_MD_DOWNLOAD] = top_q.download;
                rd_word[`SSP_MD_UNDEFINED] = top_q.undefined;
                rd_word[`SSP_MD_LOG_EN] = top_q.log_en;
                rd_word[`SSP_MD_VDD_1V8] = top_q.vdd_1v8;
                rd_word[`SSP_MD_SDIO_IN_RISE] = top_q.in_rise;
                rd_word[`SSP_MD_SDIO_OUT_RISE] = top_q.out_rise;
            end
            default: begin
                // unmapped addresses read zero; writes there are dropped
                rd_word = 32'h0;
            end
        endcase

        // ==================================================================
        // bus answer
        // one ack per request, dropped the cycle after
        top_d.ack = bus_req;
        // data only for reads, so the lines stay quiet on writes
        if (bus_req && !wb_we_i) begin
            top_d.rdata = rd_word;
        end else begin
            top_d.rdata = 32'h0;
        end
    end

    // ======================================================================
    // registers
    // pads and sequencer clear together on the same reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            top_q.state <= ssp_pkg::SSP_ST_OFF;
            top_q.settle <= '0;
            top_q.captured <= 1'b0;
            // zero is masked by the decode; capture reloads from the straps
            top_q.ovr <= `SSP_OV_RESET;
            top_q.ack <= 1'b0;
            top_q.rdata <= 32'h0;
            top_q.run <= 1'b0;
            top_q.flash_boot <= 1'b0;
            top_q.download <= 1'b0;
            top_q.undefined <= 1'b0;
            top_q.log_en <= 1'b0;
            top_q.vdd_1v8 <= 1'b0;
            top_q.in_rise <= 1'b0;
            top_q.out_rise <= 1'b0;
        end else begin
            top_q <= top_d;
        end
    end

    // ======================================================================
    // outputs
    // every output is a state flop, none passes through logic
    assign chip_run = top_q.run;
    assign boot_from_flash = top_q.flash_boot;
    assign download_boot = top_q.download;
    assign boot_mode_undefined = top_q.undefined;
    assign boot_log_enable = top_q.log_en;
    assign flash_vdd_1v8 = top_q.vdd_1v8;
    assign sdio_in_rising = top_q.in_rise;
    assign sdio_out_rising = top_q.out_rise;
    assign wb_dat_o = top_q.rdata;
    assign wb_ack_o = top_q.ack;

endmodule

`default_nettype wire

// >>> verilog/ssp_map.svh
// offsets, field positions, reset values and timing counts of the strap sampler
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ==========================================================================
// strap vector bit positions
`define SSP_BIT_SUPPLY 0
`define SSP_BIT_BOOT 1
`define SSP_BIT_QUALIFY 2
`define SSP_BIT_LOG_EDGE 3
`define SSP_BIT_SDIO_EDGE 4
`define SSP_NUM_STRAPS 5

// ==========================================================================
// internal pull direction per strap, 1 = pull-up
`define SSP_PULL_UP_MASK 5'h1A

// ==========================================================================
// register byte offsets
`define SSP_OFS_STATUS 8'h00
`define SSP_OFS_OVERRIDE 8'h04
`define SSP_OFS_MODE 8'h08

// ==========================================================================
// status register fields
`define SSP_ST_STRAPS_LSB 0
`define SSP_ST_CAPTURED 8
`define SSP_ST_RUNNING 9

// ==========================================================================
// override register fields and reset value
`define SSP_OV_VDD_1V8 0
`define SSP_OV_SDIO_IN_RISE 1
`define SSP_OV_SDIO_OUT_RISE 2
`define SSP_OV_WIDTH 3
`define SSP_OV_RESET 3'h0

// ==========================================================================
// mode register fields
`define SSP_MD_FLASH_BOOT 0
`define SSP_MD_DOWNLOAD 1
`define SSP_MD_UNDEFINED 2
`define SSP_MD_LOG_EN 3
`define SSP_MD_VDD_1V8 4
`define SSP_MD_SDIO_IN_RISE 5
`define SSP_MD_SDIO_OUT_RISE 6

// ==========================================================================
// pin settle time before the strap latch closes
`define SSP_SETTLE_NS 50
`define SSP_CLK_MHZ 100
`define SSP_SETTLE_CYC ((`SSP_SETTLE_NS * `SSP_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/ssp_pkg.sv
// types shared by the strap sampler files
package ssp_pkg;

    // ======================================================================
    // sequencer states
    typedef enum logic [1:0] {
        SSP_ST_OFF = 2'b00,
        SSP_ST_SETTLE = 2'b01,
        SSP_ST_RUN = 2'b10
    } ssp_state_e;

endpackage

// >>> verilog/ssp_strap_pad.sv
// one strapping pad: weak pull, strap latch and functional pass-through
`timescale 1ns/10ps
`default_nettype none

module ssp_strap_pad #(
    parameter bit PULL_UP = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hold,
    input wire logic sample,
    input wire logic pin_i,
    input wire logic func_o,
    input wire logic func_oe,
    output logic pin_o,
    output logic pin_oe,
    output logic pull_up_en,
    output logic pull_dn_en,
    output logic strap_q
);

    typedef struct packed {
        logic strap;
        logic pin_o;
        logic pin_oe;
        logic pull_up_en;
        logic pull_dn_en;
    } ssp_pad_s;

    ssp_pad_s pad_q;
    ssp_pad_s pad_d;

    always_comb begin
        pad_d = pad_q;
        if (hold) begin
            // pad stays an input under its weak pull
            pad_d.pull_up_en = PULL_UP;
            pad_d.pull_dn_en = ~PULL_UP;
            pad_d.pin_o = 1'b0;
            pad_d.pin_oe = 1'b0;
            if (sample) begin
                pad_d.strap = pin_i;
            end
        end else begin
            // latch is left alone, pin goes back to its normal job
            pad_d.pull_up_en = 1'b0;
            pad_d.pull_dn_en = 1'b0;
            pad_d.pin_o = func_o;
            pad_d.pin_oe = func_oe;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pad_q.strap <= PULL_UP;
            pad_q.pin_o <= 1'b0;
            pad_q.pin_oe <= 1'b0;
            pad_q.pull_up_en <= PULL_UP;
            pad_q.pull_dn_en <= ~PULL_UP;
        end else begin
            pad_q <= pad_d;
        end
    end

    assign pin_o = pad_q.pin_o;
    assign pin_oe = pad_q.pin_oe;
    assign pull_up_en = pad_q.pull_up_en;
    assign pull_dn_en = pad_q.pull_dn_en;
    assign strap_q = pad_q.strap;

endmodule

`default_nettype wire

// >>> test/ssp_board_model.sv
// board side of the strap pins: resistors or host gpio plus wire resolve
`timescale 1ns/10ps
`default_nettype none

module ssp_board_model #(
    parameter int N = 5
) (
    input wire logic clock,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    input wire logic [N-1:0] pin_o,
    input wire logic [N-1:0] pin_oe,
    input wire logic [N-1:0] pull_up_en,
    input wire logic [N-1:0] pull_dn_en,
    output logic [N-1:0] pin_i
);
    // =====================================================================
    // undriven and unpulled lines wander so a stale level never passes
    logic [N-1:0] float_q = '0;
    always_ff @(posedge clock) begin
        float_q <= ~float_q;
    end

    // =====================================================================
    // strong drivers first, weak pulls only when nobody drives
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else if (pull_up_en[i] || pull_dn_en[i]) begin
                pin_i[i] = pull_up_en[i];
            end else begin
                pin_i[i] = float_q[i];
            end
        end
    end
endmodule

`default_nettype wire

// >>> test/ssp_strap_sampler_chk.sv
// concurrent checks on the strap sampler ports
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.svh"

module ssp_strap_sampler_chk #(
    parameter int NUM_STRAPS = 5,
    parameter int SETTLE_CYC = 5
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_enable,
    input wire logic [NUM_STRAPS-1:0] func_oe,
    input wire logic [NUM_STRAPS-1:0] strap_pin_oe,
    input wire logic [NUM_STRAPS-1:0] strap_pull_up_en,
    input wire logic [NUM_STRAPS-1:0] strap_pull_dn_en,
    input wire logic chip_run,
    input wire logic boot_from_flash,
    input wire logic download_boot,
    input wire logic boot_mode_undefined,
    input wire logic boot_log_enable,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    localparam int RUN_MAX = 60;
    localparam logic [NUM_STRAPS-1:0] UP = NUM_STRAPS'(`SSP_PULL_UP_MASK);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // =====================================================================
    // cycles spent enabled but not yet running
    int wait_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_q <= 0;
        end else if (chip_enable && !chip_run) begin
            wait_q <= wait_q + 1;
        end else begin
            wait_q <= 0;
        end
    end

    sequence steady_run;
        chip_run && $past(chip_run) && chip_enable && $past(chip_enable);
    endsequence
    sequence held_off;
        !chip_run && !$past(chip_run);
    endsequence
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    // =====================================================================
    chk_ack_latency: assert property (wb_req |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    chk_run_enable: assert property (!chip_enable |=> !chip_run)
        else $error("chip runs while enable low");
    chk_settle_count: assert property ($rose(chip_run)
        |-> wait_q == SETTLE_CYC + 1)
        else $error("capture not at end of settle window");
    chk_run_latency: assert property ($rose(chip_enable)
        |-> ##[1:RUN_MAX] (chip_run || !chip_enable))
        else $error("chip never started after enable");
    chk_pull_hold: assert property (held_off |-> strap_pull_up_en == UP
        && strap_pull_dn_en == ~UP && strap_pin_oe == '0)
        else $error("pulls wrong or pin driven during hold");
    chk_pin_release: assert property (steady_run |-> strap_pull_up_en == '0
        && strap_pull_dn_en == '0 && strap_pin_oe == $past(func_oe))
        else $error("pins not handed to function after capture");
    chk_boot_onehot: assert property (chip_run |-> $onehot({boot_from_flash,
        download_boot, boot_mode_undefined}))
        else $error("boot decode not one hot");
    chk_straps_hold: assert property (steady_run |-> $stable(boot_from_flash)
        && $stable(boot_log_enable) && $stable(download_boot))
        else $error("latched decode changed while running");
    chk_idle_clear: assert property (held_off |-> !boot_from_flash
        && !download_boot && !boot_log_enable)
        else $error("decode visible while not captured");
endmodule

bind ssp_strap_sampler ssp_strap_sampler_chk #(.NUM_STRAPS(NUM_STRAPS),
    .SETTLE_CYC(SETTLE_CYC)) u_ssp_strap_sampler_chk (.clock(clock),
    .reset(reset), .chip_enable(chip_enable), .func_oe(func_oe),
    .strap_pin_oe(strap_pin_oe), .strap_pull_up_en(strap_pull_up_en),
    .strap_pull_dn_en(strap_pull_dn_en), .chip_run(chip_run),
    .boot_from_flash(boot_from_flash), .download_boot(download_boot),
    .boot_mode_undefined(boot_mode_undefined),
    .boot_log_enable(boot_log_enable), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

`default_nettype wire

// >>> test/ssp_strap_sampler_tb.sv
// self-checking bench for the strap sampler
`timescale 1ns/10ps
`default_nettype none

module ssp_strap_sampler_tb;
    localparam int SET = 2;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic chip_enable = 1'b1;
    logic [4:0] ext_en = 5'h00, ext_val = 5'h00;
    logic [4:0] func_o = 5'h00, func_oe = 5'h00;
    logic [4:0] pin_i, pin_o, pin_oe, pu_en, pd_en;
    logic run, flash, dl, und, log_en, vdd, sin, sout, ack;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, rd;
    logic [4:0] vecs [4] = '{5'h00, 5'h15, 5'h0A, 5'h1F};
    int bad_count = 0, n_compared = 0, cycles = 0;

    always #5 clock = ~clock;

    ssp_strap_sampler #(.SETTLE_CYC(SET)) u_ssp_strap_sampler (.clock(clock),
        .reset(reset), .chip_enable(chip_enable), .strap_pin_i(pin_i),
        .strap_pin_o(pin_o), .strap_pin_oe(pin_oe), .strap_pull_up_en(pu_en),
        .strap_pull_dn_en(pd_en), .func_o(func_o), .func_oe(func_oe),
        .chip_run(run), .boot_from_flash(flash), .download_boot(dl),
        .boot_mode_undefined(und), .boot_log_enable(log_en),
        .flash_vdd_1v8(vdd), .sdio_in_rising(sin), .sdio_out_rising(sout),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
    ssp_board_model #(.N(5)) u_ssp_board_model (.clock(clock),
        .ext_en(ext_en), .ext_val(ext_val), .pin_o(pin_o), .pin_oe(pin_oe),
        .pull_up_en(pu_en), .pull_dn_en(pd_en), .pin_i(pin_i));

    // =====================================================================
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; a hang is cut by the cycle ceiling
    task automatic wb(logic w, logic [7:0] a, logic [3:0] s, logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic reg_chk(string what, logic [7:0] a, logic [31:0] exp);
        wb(1'b0, a, 4'hF, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic wait_run();
        do @(posedge clock); while (run !== 1'b1);
        repeat (2) @(posedge clock);
    endtask

    // board holds the straps through a full disable and re-enable
    task automatic power(logic [4:0] v);
        @(posedge clock);
        chip_enable <= 1'b0;
        ext_en <= 5'h1F;
        ext_val <= v;
        repeat (3) @(posedge clock);
        check("off decode", {run, flash, dl, log_en}, 32'h0);
        check("off config", {und, vdd, sin, sout}, 32'h0);
        chip_enable <= 1'b1;
        wait_run();
        ext_en <= 5'h00;
    endtask

    task automatic verify(logic [4:0] v);
        logic [6:0] md;
        md = {v[4], v[3], v[0], v[3], ~v[1] & v[2], ~v[1] & ~v[2], v[1]};
        @(posedge clock);
        check("decode", {sout, sin, vdd, log_en, und, dl, flash}, md);
        reg_chk("status", 8'h00, {22'h0, 2'h3, 3'h0, v});
        reg_chk("mode", 8'h08, {25'h0, md});
        reg_chk("override", 8'h04, {29'h0, v[4], v[3], v[0]});
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        wait_run();
        verify(5'h1A);
        $display("test pull defaults done");
        ext_en <= 5'h1F;
        ext_val <= 5'h05;
        func_o <= 5'h0C;
        func_oe <= 5'h1F;
        repeat (4) @(posedge clock);
        check("pins", {pin_oe, pin_o, pu_en, pd_en}, 32'h000F_B000);
        func_oe <= 5'h00;
        ext_en <= 5'h00;
        verify(5'h1A);
        $display("test pin release done");
        wb(1'b1, 8'h04, 4'hF, 32'h5);
        repeat (2) @(posedge clock);
        check("override out", {sout, sin, vdd}, 32'h5);
        wb(1'b1, 8'h04, 4'hE, 32'h2);
        reg_chk("masked write", 8'h04, 32'h5);
        wb(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        reg_chk("status ro", 8'h00, 32'h31A);
        wb(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        reg_chk("unmapped", 8'h10, 32'h0);
        $display("test registers done");
        foreach (vecs[i]) begin
            power(vecs[i]);
            verify(vecs[i]);
        end
        $display("test strap table done");
        chip_enable <= 1'b0;
        repeat (3) @(posedge clock);
        check("shutdown", {run, flash, dl, und, log_en}, 32'h0);
        $display("test shutdown done");
        finish_test();
    end
endmodule

`default_nettype wire
